// >>> bench/ifp_core_model.sv
// behavioural processor core that takes presented vectors, promptly or after a wait
`timescale 1ns/10ps
module ifp_core_model
  import ifp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire ifp_vector_type vector_req,
  input wire logic slow,
  output logic core_accept,
  output logic [23:0] last_addr,
  output logic last_high,
  output int n_taken
);
  int wait_cnt;
  // ****************************************
  // accept: one-cycle pulse, never twice back to back
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      core_accept <= 1'b0;
      wait_cnt <= 0;
      n_taken <= 0;
      last_addr <= 24'h0;
      last_high <= 1'b0;
    end
    else if (core_accept)
    begin
      core_accept <= 1'b0;
      wait_cnt <= 0;
    end
    else if (vector_req.valid)
    begin
      if (wait_cnt >= (slow ? 3 : 0))
      begin
        core_accept <= 1'b1;
        last_addr <= vector_req.addr;
        last_high <= vector_req.high;
        n_taken <= n_taken + 1;
      end
      else
        wait_cnt <= wait_cnt + 1;
    end
  end
endmodule : ifp_core_model

// >>> bench/ifp_regs_tb.sv
// self-checking bench for the interrupt flag and priority registers
`timescale 1ns/10ps
module ifp_regs_tb;
  import ifp_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  ifp_event_type event_in = '0;
  logic rx_buffer_full = 1'b0;
  logic tx_buffer_empty = 1'b1;
  logic [1:0] capcomp_a_mode = 2'h0;
  logic [1:0] capcomp_b_mode = 2'h0;
  logic core_accept;
  logic slow = 1'b0;
  ifp_vector_type vector_req;
  logic [23:0] last_addr;
  logic last_high;
  int n_taken;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] q;
  logic [4:0] a;
  localparam logic [4:0] RA [4] = '{5'h00, 5'h04, 5'h08, 5'h0C};
  localparam logic [7:0] ONES [4] = '{8'hDB, 8'hDF, 8'hDF, 8'h0F};
  localparam logic [7:0] ZEROS [4] = '{8'h00, 8'h00, 8'h10, 8'h00};
  // flag bit of each event_in member, ext2 first
  localparam int EV_BIT [12] = '{1, 0, 7, 6, 3, 2, 1, 0, 3, 2, 1, 0};

  always #20 clk_sys = ~clk_sys;

  ifp_regs u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .event_in(event_in), .rx_buffer_full(rx_buffer_full), .tx_buffer_empty(tx_buffer_empty),
    .capcomp_a_mode(capcomp_a_mode), .capcomp_b_mode(capcomp_b_mode),
    .core_accept(core_accept), .vector_req(vector_req));

  ifp_core_model u_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .vector_req(vector_req),
    .slow(slow), .core_accept(core_accept), .last_addr(last_addr), .last_high(last_high),
    .n_taken(n_taken));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk

  // waitrequest and read data taken at the rising edge, before its updates land
  task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= adr;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge clk_sys);
      n++;
    end
    q = avs_readdata;
    if (n >= 50)
      chk("bus answer", 32'h0, 32'h1);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic rd(input logic [4:0] adr, input logic [31:0] exp, input string what);
    bus(1'b0, adr, 32'h0);
    chk(what, exp, q);
  endtask : rd

  task automatic pulse(input int i);
    event_in <= ifp_event_type'(12'h001 << (11 - i));
    @(posedge clk_sys);
    event_in <= '0;
    @(posedge clk_sys);
  endtask : pulse

  task automatic taken(input int target, input logic [23:0] exp);
    int n;
    n = 0;
    while (n_taken < target && n < 50)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 50)
      chk("vector taken", 32'h1, 32'h0);
    chk("vectors taken", target, n_taken);
    chk("vector address", {8'h00, exp}, {8'h00, last_addr});
    @(posedge clk_sys);
  endtask : taken

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fail_count++;
      summarize();
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd(RA[0], 32'hC0, "ext reset");
    rd(RA[1], 32'h1C, "rst ctrl reset");
    for (int r = 0; r < 4; r++)
    begin
      bus(1'b1, RA[r], 32'hFF);
      rd(RA[r], {24'h0, ONES[r]}, "all ones");
      bus(1'b1, RA[r], 32'h0);
      rd(RA[r], {24'h0, ZEROS[r]}, "all zeros");
    end
    tx_buffer_empty <= 1'b0;
    // flags latch with every enable off
    for (int i = 0; i < 12; i++)
    begin
      a = (i < 2) ? 5'h00 : (i < 8) ? 5'h08 : 5'h0C;
      pulse(i);
      repeat (3) @(posedge clk_sys);
      rd(a, 32'h1 << EV_BIT[i], "event flag");
      bus(1'b1, a, 32'h0);
      rd(a, 32'h0, "event flag cleared");
    end
    capcomp_a_mode <= IFP_CCP_PWM;
    capcomp_b_mode <= IFP_CCP_PWM;
    pulse(5);
    pulse(11);
    rd(RA[2], 32'h0, "capcomp a pwm");
    rd(RA[3], 32'h0, "capcomp b pwm");
    capcomp_a_mode <= 2'h0;
    capcomp_b_mode <= 2'h0;
    rx_buffer_full <= 1'b1;
    bus(1'b1, RA[2], 32'h30);
    rd(RA[2], 32'h20, "rx tx live");
    rx_buffer_full <= 1'b0;
    rd(5'h1C, 32'h0, "unmapped");
    // compat mode: peripheral needs the group enable
    bus(1'b1, 5'h14, 32'h010);
    bus(1'b1, 5'h10, 32'h2);
    pulse(7);
    repeat (5) @(posedge clk_sys);
    chk("no vector", 32'h0, n_taken);
    bus(1'b1, 5'h10, 32'h3);
    taken(1, IFP_VEC_HIGH);
    rd(5'h10, 32'h1, "global after accept");
    bus(1'b1, RA[2], 32'h0);
    // priority levels, slow core
    bus(1'b1, RA[1], 32'h80);
    bus(1'b1, 5'h18, 32'hFEF);
    bus(1'b1, 5'h10, 32'h1);
    slow <= 1'b1;
    pulse(7);
    taken(2, IFP_VEC_LOW);
    chk("low vector level", 32'h0, {31'h0, last_high});
    rd(5'h10, 32'h0, "low global cleared");
    bus(1'b1, RA[2], 32'h0);
    bus(1'b1, RA[0], 32'h48);
    pulse(1);
    pulse(7);
    bus(1'b1, 5'h10, 32'h3);
    taken(3, IFP_VEC_HIGH);
    taken(4, IFP_VEC_LOW);
    rd(5'h10, 32'h0, "both globals cleared");
    // back to compat: priority bits ignored
    bus(1'b1, RA[2], 32'h0);
    bus(1'b1, RA[0], 32'h0);
    bus(1'b1, RA[1], 32'h0);
    bus(1'b1, 5'h10, 32'h3);
    pulse(7);
    taken(5, IFP_VEC_HIGH);
    summarize();
  end
endmodule : ifp_regs_tb

// >>> hdl/ifp_pkg.sv
// constants and types for the interrupt flag and priority register block
package ifp_pkg;
  // ****************************************
  // register map (byte addresses, one word each)
  // ****************************************
  localparam logic [3:0] IFP_ADDR_EXT = 4'h0;
  localparam logic [3:0] IFP_ADDR_RST = 4'h4;
  localparam logic [3:0] IFP_ADDR_PFA = 4'h8;
  localparam logic [3:0] IFP_ADDR_PFB = 4'hC;
  // core control: bit1 high/global enable, bit0 low/group enable
  localparam logic [4:0] IFP_ADDR_GEN = 5'h10;
  localparam logic [4:0] IFP_ADDR_PEN = 5'h14;
  localparam logic [4:0] IFP_ADDR_PPR = 5'h18;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int IFP_EXT2_PRIO = 7;
  localparam int IFP_EXT1_PRIO = 6;
  localparam int IFP_EXT2_EN = 4;
  localparam int IFP_EXT1_EN = 3;
  localparam int IFP_EXT2_FLAG = 1;
  localparam int IFP_EXT1_FLAG = 0;
  localparam logic [7:0] IFP_EXT_MASK = 8'hDB;
  localparam logic [7:0] IFP_RST_MASK = 8'hDF;
  localparam logic [7:0] IFP_PFA_WMASK = 8'hCF;
  localparam logic [7:0] IFP_PFB_MASK = 8'h0F;
  localparam logic [7:0] IFP_RST_RESET = 8'h1C;
  localparam logic [7:0] IFP_EXT_RESET = 8'hC0;
  localparam logic [23:0] IFP_VEC_HIGH = 24'h000008;
  localparam logic [23:0] IFP_VEC_LOW = 24'h000018;
  localparam logic [1:0] IFP_CCP_PWM = 2'h2;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic ext2;
    logic ext1;
    logic psp;
    logic adc;
    logic ssp;
    logic ccp_a;
    logic tmr_b;
    logic tmr_a;
    logic bcl;
    logic lvd;
    logic tmr_c;
    logic ccp_b;
  } ifp_event_type;
  typedef struct packed {
    logic valid;
    logic high;
    logic [23:0] addr;
  } ifp_vector_type;
  typedef enum logic {IFP_IDLE, IFP_ANSWER} ifp_bus_state_type;
endpackage : ifp_pkg

// >>> hdl/ifp_regs.sv
// interrupt flag, enable, priority registers with vector request to the core
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/10ps
module ifp_regs
  import ifp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire ifp_event_type event_in,
  input wire logic rx_buffer_full,
  input wire logic tx_buffer_empty,
  input wire logic [1:0] capcomp_a_mode,
  input wire logic [1:0] capcomp_b_mode,
  input wire logic core_accept,
  output ifp_vector_type vector_req
);
  // ****************************************
  // state
  // ****************************************
  logic [7:0] ext_line_irq_ctrl;
  logic [7:0] reset_cause_prio_ctrl;
  logic [7:0] periph_request_flags_a;
  logic [7:0] periph_request_flags_b;
  logic [11:0] periph_enables;
  logic [11:0] periph_priorities;
  logic global_high_enable;
  logic global_low_enable;
  ifp_bus_state_type bus_state;
  logic wr_go;
  logic rd_go;
  logic [7:0] wdat;
  logic [7:0] set_a;
  logic [7:0] set_b;
  logic [7:0] rd_a;
  logic priority_levels_on;
  logic [13:0] req_flag;
  logic [13:0] req_en;
  logic [13:0] req_prio;
  logic [13:0] req_periph;
  logic [13:0] active;
  logic any_high;
  logic any_low;

  // ****************************************
  // bus slave: one wait cycle, answer on second
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      bus_state <= IFP_IDLE;
    else if (bus_state == IFP_ANSWER)
      bus_state <= IFP_IDLE;
    else if (avs_read || avs_write)
      bus_state <= IFP_ANSWER;
  end

  assign avs_waitrequest = (avs_read || avs_write) && (bus_state == IFP_IDLE);
  assign wr_go = avs_write && (bus_state == IFP_ANSWER) && avs_byteenable[0];
  assign rd_go = avs_read && (bus_state == IFP_ANSWER);
  assign wdat = avs_writedata[7:0];
  assign priority_levels_on = reset_cause_prio_ctrl[7];

  // ****************************************
  // event capture
  // ****************************************
  always_comb
  begin
    set_a = 8'h00;
    set_b = 8'h00;
    set_a[7] = event_in.psp;
    set_a[6] = event_in.adc;
    set_a[3] = event_in.ssp;
    set_a[2] = event_in.ccp_a && (capcomp_a_mode != IFP_CCP_PWM);
    set_a[1] = event_in.tmr_b;
    set_a[0] = event_in.tmr_a;
    set_b[3] = event_in.bcl;
    set_b[2] = event_in.lvd;
    set_b[1] = event_in.tmr_c;
    set_b[0] = event_in.ccp_b && (capcomp_b_mode != IFP_CCP_PWM);
  end

  // flags set regardless of enables; a set beats a same-cycle clear
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ext_line_irq_ctrl <= IFP_EXT_RESET;
    else
    begin
      if (wr_go && avs_address == {1'b0, IFP_ADDR_EXT})
        ext_line_irq_ctrl <= wdat & IFP_EXT_MASK;
      if (event_in.ext2)
        ext_line_irq_ctrl[IFP_EXT2_FLAG] <= 1'b1;
      if (event_in.ext1)
        ext_line_irq_ctrl[IFP_EXT1_FLAG] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      periph_request_flags_a <= 8'h00;
    else if (wr_go && avs_address == {1'b0, IFP_ADDR_PFA})
      periph_request_flags_a <= (wdat & IFP_PFA_WMASK) | set_a;
    else
      periph_request_flags_a <= periph_request_flags_a | set_a;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      periph_request_flags_b <= 8'h00;
    else if (wr_go && avs_address == {1'b0, IFP_ADDR_PFB})
      periph_request_flags_b <= (wdat & IFP_PFB_MASK) | set_b;
    else
      periph_request_flags_b <= periph_request_flags_b | set_b;
  end

  // live status bits, never stored
  always_comb
  begin
    rd_a = periph_request_flags_a & IFP_PFA_WMASK;
    rd_a[5] = rx_buffer_full;
    rd_a[4] = tx_buffer_empty;
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      reset_cause_prio_ctrl <= IFP_RST_RESET;
    else if (wr_go && avs_address == {1'b0, IFP_ADDR_RST})
      reset_cause_prio_ctrl <= wdat & IFP_RST_MASK;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      periph_enables <= 12'h000;
      periph_priorities <= 12'hFFF;
    end
    else
    begin
      if (avs_write && (bus_state == IFP_ANSWER) && avs_address == IFP_ADDR_PEN)
        periph_enables <= avs_writedata[11:0];
      if (avs_write && (bus_state == IFP_ANSWER) && avs_address == IFP_ADDR_PPR)
        periph_priorities <= avs_writedata[11:0];
    end
  end

  // acceptance clears the gating enable; bus write of same bit loses to accept
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      global_high_enable <= 1'b0;
      global_low_enable <= 1'b0;
    end
    else
    begin
      if (wr_go && avs_address == IFP_ADDR_GEN)
      begin
        global_high_enable <= wdat[1];
        global_low_enable <= wdat[0];
      end
      if (core_accept && vector_req.valid)
      begin
        if (!priority_levels_on || vector_req.high)
          global_high_enable <= 1'b0;
        else
          global_low_enable <= 1'b0;
      end
    end
  end

  // ****************************************
  // request arbitration
  // ****************************************
  // software is expected to clear stale flags before enabling
  assign req_flag = {ext_line_irq_ctrl[IFP_EXT2_FLAG], ext_line_irq_ctrl[IFP_EXT1_FLAG],
                     rd_a, periph_request_flags_b[3:0]};
  assign req_en = {ext_line_irq_ctrl[IFP_EXT2_EN], ext_line_irq_ctrl[IFP_EXT1_EN],
                   periph_enables};
  assign req_prio = {ext_line_irq_ctrl[IFP_EXT2_PRIO], ext_line_irq_ctrl[IFP_EXT1_PRIO],
                     periph_priorities};
  assign req_periph = {2'b00, 12'hFFF};
  assign active = req_flag & req_en;

  always_comb
  begin
    if (priority_levels_on)
    begin
      any_high = global_high_enable && |(active & req_prio);
      any_low = global_low_enable && |(active & ~req_prio);
    end
    else
    begin
      // low enable acts as peripheral group enable here
      any_high = global_high_enable &&
                 |(active & (~req_periph | {14{global_low_enable}}));
      any_low = 1'b0;
    end
  end

  // registered request: core sees a stable vector, at the cost of one cycle latency
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      vector_req <= '0;
    else if (core_accept && vector_req.valid)
      vector_req <= '0;
    else if (any_high)
      vector_req <= '{valid: 1'b1, high: 1'b1, addr: IFP_VEC_HIGH};
    else if (any_low)
      vector_req <= '{valid: 1'b1, high: 1'b0, addr: IFP_VEC_LOW};
    else
      vector_req <= '0;
  end

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      avs_readdata <= 32'h00000000;
    else if (avs_read && bus_state == IFP_IDLE)
    begin
      case (avs_address)
        {1'b0, IFP_ADDR_EXT}: avs_readdata <= {24'h000000, ext_line_irq_ctrl};
        {1'b0, IFP_ADDR_RST}: avs_readdata <= {24'h000000, reset_cause_prio_ctrl};
        {1'b0, IFP_ADDR_PFA}: avs_readdata <= {24'h000000, rd_a};
        {1'b0, IFP_ADDR_PFB}: avs_readdata <= {24'h000000, periph_request_flags_b};
        IFP_ADDR_GEN: avs_readdata <= {30'h00000000, global_high_enable, global_low_enable};
        IFP_ADDR_PEN: avs_readdata <= {20'h00000, periph_enables};
        IFP_ADDR_PPR: avs_readdata <= {20'h00000, periph_priorities};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  ext_reset_val_a: assert property (@(posedge clk_sys)
    $fell(sys_rst) |-> ext_line_irq_ctrl == IFP_EXT_RESET)
    else $error("ext control reset value wrong");
  ext_unimpl_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ext_line_irq_ctrl[5] == 1'b0) && (ext_line_irq_ctrl[2] == 1'b0))
    else $error("unimplemented ext bits nonzero");
  pfb_upper_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    periph_request_flags_b[7:4] == 4'h0)
    else $error("flags b upper bits nonzero");
  ext_flag_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    event_in.ext1 |=> ext_line_irq_ctrl[IFP_EXT1_FLAG])
    else $error("ext1 flag not set");
  flag_sticky_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    periph_request_flags_b[3] && !wr_go |=> periph_request_flags_b[3])
    else $error("collision flag lost");
  adc_flag_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    event_in.adc |=> periph_request_flags_a[6])
    else $error("conversion flag not set");
  rx_live_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_go && avs_address == {1'b0, IFP_ADDR_PFA} |->
    avs_readdata[5] == $past(rx_buffer_full))
    else $error("rx status not live");
  compat_vec_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    vector_req.valid && !$past(priority_levels_on) |-> vector_req.addr == IFP_VEC_HIGH)
    else $error("compat vector wrong");
  low_vec_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    vector_req.valid && !vector_req.high |-> vector_req.addr == IFP_VEC_LOW)
    else $error("low vector wrong");
  accept_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    core_accept && vector_req.valid && vector_req.high |=> !global_high_enable)
    else $error("high enable not cleared");
  high_first_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    any_high && !(core_accept && vector_req.valid) |=> vector_req.high)
    else $error("high request not first");
  wait_one_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer timing");
  high_req_c: cover property (@(posedge clk_sys) vector_req.valid && vector_req.high);
  low_req_c: cover property (@(posedge clk_sys) vector_req.valid && !vector_req.high);
  set_clear_c: cover property (@(posedge clk_sys) wr_go && |set_a);
endmodule : ifp_regs
